/* File: cpsc_defs.vh */
// constants of the clock prescale and sleep control block
`ifndef CPSC_DEFS_VH
`define CPSC_DEFS_VH

// register indexes; byte address is four times the index
`define CPSC_IDX_PRESCALE   10'h061
`define CPSC_IDX_TRIM       10'h066
`define CPSC_IDX_SLEEP      10'h053
`define CPSC_IDX_STATUS     10'h054

// clock_prescale fields and values
`define CPSC_PCE_BIT        7
`define CPSC_DIVSEL_MSB     3
`define CPSC_DIVSEL_LSB     0
`define CPSC_PCE_ONLY       8'h80
`define CPSC_DIVSEL_MAX     4'h8
`define CPSC_DIV_RST_FUSE   4'h3
`define CPSC_DIV_RST_NOFUSE 4'h0

// oscillator_trim fields
`define CPSC_TRIM_RANGE_BIT 7
`define CPSC_TRIM_RST       8'h00

// sleep_control_reg fields and mode codes
`define CPSC_SE_BIT         0
`define CPSC_SM_MSB         3
`define CPSC_SM_LSB         1
`define CPSC_SLP_RST        4'h0
`define CPSC_SM_IDLE        3'h0
`define CPSC_SM_QUIET       3'h1
`define CPSC_SM_PDOWN       3'h2
`define CPSC_SM_PSAVE       3'h3
`define CPSC_SM_RSV4        3'h4
`define CPSC_SM_RSV5        3'h5
`define CPSC_SM_STBY        3'h6
`define CPSC_SM_ESTBY       3'h7

// timing counts in cycles
`define CPSC_PCE_WINDOW     3'h4
`define CPSC_HALT_CYCLES    4'h4
`define CPSC_STBY_WAKE      4'h6
`define CPSC_OSC_STARTUP    4'h6
`define CPSC_INIT_CYCLES    2'h3

`endif

/* File: cpsc_sync.v */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module cpsc_sync #(
   parameter W = 1
) (
   input  wire         clk,     // sampling clock
   input  wire         nrst,    // async reset, active low
   input  wire         clk_en,  // freeze when low
   input  wire [W-1:0] d,       // asynchronous inputs
   output reg  [W-1:0] q        // synchronised outputs
);
   reg [W-1:0] meta_reg;

   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         meta_reg <= {W{1'b0}};
         q        <= {W{1'b0}};
      end
      else if (clk_en)
      begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule // cpsc_sync
`default_nettype wire

/* File: cpsc_top.v */
// clock prescaler, oscillator trim and sleep control with apb registers
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "cpsc_defs.vh"

// How it works
// - reset loads factory trim; writes retune oscillator
// - top trim bit selects low/high range
// - low seven bits tune within range
// - change enable sets only on 0x80 write
// - change enable clears after four or divide write
// - rewriting change enable neither restarts nor clears
// - divide select gives factor two to power
// - divided tick drives cpu and peripherals
// - reset divide is zero or three by fuse
// - any legal divide accepted regardless of fuse
// - sleep needs enable bit plus sleep instruction
// - each mode gates its own clock set
// - wake sources depend on sleep mode
// - upper external lines wake only when level, except in idle mode
// - timer oscillator kept only for async timer2
// - cpu halted four cycles after start-up
// - wake leaves register file and sram intact
// - reset in sleep restarts from reset vector
// - mode encoding per three select bits
// - divide changes happen without short periods
// - standby wake-up takes six cycles
module cpsc_top (
   input  wire        core_clk,             // undivided master clock
   input  wire        nrst,                 // async reset, active low
   input  wire        clk_en,               // freezes all state when low
   input  wire        psel,                 // apb select
   input  wire        penable,              // apb enable
   input  wire        pwrite,               // apb direction
   input  wire [11:0] paddr,                // apb byte address
   input  wire [31:0] pwdata,               // apb write data
   output reg  [31:0] prdata,               // apb read data
   output reg         pready,               // apb ready
   output reg         pslverr,              // apb error, unmapped address
   input  wire        divide_by_eight_fuse, // fuse strap pin
   input  wire [7:0]  factory_trim,         // factory calibration pins
   input  wire        sleep_instr,          // cpu executes sleep, pulse
   input  wire [7:0]  ext_irq_lines,        // external interrupt pins
   input  wire [3:0]  ext_irq_upper_level,  // upper lines in level mode
   input  wire        pin_change_irq,       // pin change pin
   input  wire        twi_addr_match,       // two_wire_interface match
   input  wire        watchdog_irq,         // watchdog_unit interrupt
   input  wire        timer2_irq,           // timer2 interrupt
   input  wire        timer2_async,         // timer2 on async clock
   input  wire        mem_ready_irq,        // self_program_store or eeprom ready
   input  wire        adc_irq,              // converter done
   input  wire        other_io_irq,         // any other io interrupt
   output reg         sys_clk_en,           // divided clock enable tick
   output reg  [7:0]  trim_value,           // oscillator trim to analog
   output reg         cpu_clk_run,          // cpu clock gate
   output reg         flash_clk_run,        // flash clock gate
   output reg         io_clk_run,           // io clock gate
   output reg         adc_clk_run,          // converter clock gate
   output reg         async_clk_run,        // async_timer_clock gate
   output reg         main_osc_run,         // main source enable
   output reg         timer_osc_run,        // timer oscillator enable
   output reg         cpu_halt,             // cpu held while not active
   output reg         cpu_resume,           // pulse, wake sequence done
   output reg         sleeping              // device in a sleep state
);
   localparam ST_ACTIVE = 2'h0;
   localparam ST_SLEEP  = 2'h1;
   localparam ST_START  = 2'h2;
   localparam ST_HALT   = 2'h3;

   localparam [11:0] A_PRE = {`CPSC_IDX_PRESCALE, 2'b00};
   localparam [11:0] A_TRM = {`CPSC_IDX_TRIM, 2'b00};
   localparam [11:0] A_SLP = {`CPSC_IDX_SLEEP, 2'b00};
   localparam [11:0] A_STA = {`CPSC_IDX_STATUS, 2'b00};

   wire [17:0] sync_q;
   wire [7:0]  ext_s   = sync_q[7:0];
   wire        pin_s   = sync_q[8];
   wire [7:0]  ftrim_s = sync_q[16:9];
   wire        fuse_s  = sync_q[17];

   cpsc_sync #(
      .W (18)
   ) u_sync (
      .clk    (core_clk),
      .nrst   (nrst),
      .clk_en (clk_en),
      .d      ({divide_by_eight_fuse, factory_trim, pin_change_irq, ext_irq_lines}),
      .q      (sync_q)
   );

   // straps captured a few cycles after reset release
   reg [1:0] init_cnt_reg;
   reg       init_done_reg;
   wire      load = ~init_done_reg & (init_cnt_reg == `CPSC_INIT_CYCLES);

   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         init_cnt_reg  <= 2'h0;
         init_done_reg <= 1'b0;
      end
      else if (clk_en && !init_done_reg)
      begin
         if (load)
            init_done_reg <= 1'b1;
         else
            init_cnt_reg <= init_cnt_reg + 2'h1;
      end
   end

   // apb decode, one wait state
   wire       hit_pre = (paddr == A_PRE);
   wire       hit_trm = (paddr == A_TRM);
   wire       hit_slp = (paddr == A_SLP);
   wire       hit_sta = (paddr == A_STA);
   wire       mapped  = hit_pre | hit_trm | hit_slp | hit_sta;
   wire       rd_phase = psel & penable & ~pready;
   wire       wr_do   = psel & penable & pready & pwrite;
   wire [7:0] wd      = pwdata[7:0];
   wire       wr_pre  = wr_do & hit_pre;
   wire       wr_trm  = wr_do & hit_trm;
   wire       wr_slp  = wr_do & hit_slp;

   reg        pce_reg;
   reg [2:0]  pce_cnt_reg;
   reg [3:0]  div_sel_reg;
   reg [3:0]  div_act_reg;
   reg [7:0]  div_cnt_reg;
   reg [3:0]  slp_ctl_reg;
   reg [1:0]  state_reg;
   reg [2:0]  mode_reg;
   reg [3:0]  wait_reg;
   reg [7:0]  rdata;

   always @*
   begin
      rdata = 8'h00;
      if (hit_pre)
         rdata = {pce_reg, 3'h0, div_sel_reg};
      else if (hit_trm)
         rdata = trim_value;
      else if (hit_slp)
         rdata = {4'h0, slp_ctl_reg};
      else if (hit_sta)
         rdata = {init_done_reg, pce_reg, state_reg, div_act_reg};
   end

   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else if (clk_en)
      begin
         pready  <= rd_phase;
         pslverr <= rd_phase & ~mapped;
         if (rd_phase)
            prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rdata};
      end
   end

   // glitch-free divider: new factor only at a boundary of the old one
   wire [8:0] mask9   = (9'h001 << div_act_reg) - 9'h001;
   wire [7:0] mask    = mask9[7:0];
   wire       sys_tick = ((div_cnt_reg & mask) == mask);

   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         div_cnt_reg <= 8'h00;
         div_act_reg <= 4'h0;
         sys_clk_en  <= 1'b0;
      end
      else if (clk_en)
      begin
         sys_clk_en <= sys_tick;
         if (sys_tick)
         begin
            div_cnt_reg <= 8'h00;
            div_act_reg <= div_sel_reg;
         end
         else
            div_cnt_reg <= div_cnt_reg + 8'h01;
      end
   end

   // change protocol
   wire pce_only = (wd == `CPSC_PCE_ONLY);
   wire div_ok   = ~wd[`CPSC_PCE_BIT] & (wd[`CPSC_DIVSEL_MSB:`CPSC_DIVSEL_LSB] <= `CPSC_DIVSEL_MAX);

   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pce_reg     <= 1'b0;
         pce_cnt_reg <= 3'h0;
         div_sel_reg <= `CPSC_DIV_RST_NOFUSE;
      end
      else if (clk_en)
      begin
         if (load)
            div_sel_reg <= fuse_s ? `CPSC_DIV_RST_FUSE : `CPSC_DIV_RST_NOFUSE;
         if (wr_pre && pce_only && !pce_reg)
         begin
            pce_reg     <= 1'b1;
            pce_cnt_reg <= 3'h0;
         end
         else if (pce_reg && wr_pre && !pce_only)
         begin
            pce_reg <= 1'b0;
            if (div_ok)
               div_sel_reg <= wd[`CPSC_DIVSEL_MSB:`CPSC_DIVSEL_LSB];
         end
         else if (pce_reg && sys_tick)
         begin
            // window counted in divided cycles; rewrite of 0x80 lands here
            if (pce_cnt_reg == `CPSC_PCE_WINDOW - 3'h1)
               pce_reg <= 1'b0;
            pce_cnt_reg <= pce_cnt_reg + 3'h1;
         end
      end
   end

   // trim register and sleep control register
   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         trim_value  <= `CPSC_TRIM_RST;
         slp_ctl_reg <= `CPSC_SLP_RST;
      end
      else if (clk_en)
      begin
         if (load)
            trim_value <= ftrim_s;
         else if (wr_trm)
            trim_value <= wd;
         if (wr_slp)
            slp_ctl_reg <= wd[3:0];
      end
   end

   // wake qualification
   wire [2:0] sm       = slp_ctl_reg[`CPSC_SM_MSB:`CPSC_SM_LSB];
   wire       mode_ok  = (sm != `CPSC_SM_RSV4) && (sm != `CPSC_SM_RSV5);
   wire       enter    = sleep_instr & slp_ctl_reg[`CPSC_SE_BIT] & mode_ok & init_done_reg;
   wire       fast_mode = (mode_reg == `CPSC_SM_IDLE) || (mode_reg == `CPSC_SM_QUIET);
   wire       stby_mode = (mode_reg == `CPSC_SM_STBY) || (mode_reg == `CPSC_SM_ESTBY);
   reg  [3:0] upper_ok;
   reg        w_t2;
   reg        w_mem;
   reg        w_oth;
   reg        wake;

   always @*
   begin
      upper_ok = ext_s[7:4];
      if (mode_reg != `CPSC_SM_IDLE)
         upper_ok = ext_s[7:4] & ext_irq_upper_level;
      w_t2  = 1'b0;
      w_mem = 1'b0;
      w_oth = 1'b0;
      case (mode_reg)
         `CPSC_SM_IDLE:
         begin
            w_t2  = 1'b1;
            w_mem = 1'b1;
            w_oth = 1'b1;
         end
         `CPSC_SM_QUIET:
         begin
            w_t2  = timer2_async;
            w_mem = 1'b1;
         end
         `CPSC_SM_PSAVE:
            w_t2 = 1'b1;
         `CPSC_SM_ESTBY:
            w_t2 = 1'b1;
         default:
            w_t2 = 1'b0;
      endcase
      wake = (|ext_s[3:0]) | (|upper_ok) | pin_s | twi_addr_match | watchdog_irq
           | (w_t2 & timer2_irq) | (w_mem & (mem_ready_irq | adc_irq))
           | (w_oth & other_io_irq);
   end

   // sleep sequencer; only clocks are gated, no state is cleared
   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_reg  <= ST_ACTIVE;
         mode_reg   <= `CPSC_SM_IDLE;
         wait_reg   <= 4'h0;
         cpu_resume <= 1'b0;
      end
      else if (clk_en)
      begin
         cpu_resume <= 1'b0;
         case (state_reg)
            ST_ACTIVE:
            begin
               if (enter)
               begin
                  state_reg <= ST_SLEEP;
                  mode_reg  <= sm;
               end
            end
            ST_SLEEP:
            begin
               if (wake)
               begin
                  if (fast_mode)
                  begin
                     state_reg <= ST_HALT;
                     wait_reg  <= `CPSC_HALT_CYCLES - 4'h1;
                  end
                  else
                  begin
                     state_reg <= ST_START;
                     wait_reg  <= (stby_mode ? `CPSC_STBY_WAKE : `CPSC_OSC_STARTUP) - 4'h1;
                  end
               end
            end
            ST_START:
            begin
               if (wait_reg == 4'h0)
               begin
                  state_reg <= ST_HALT;
                  wait_reg  <= `CPSC_HALT_CYCLES - 4'h1;
               end
               else
                  wait_reg <= wait_reg - 4'h1;
            end
            ST_HALT:
            begin
               if (wait_reg == 4'h0)
               begin
                  state_reg  <= ST_ACTIVE;
                  cpu_resume <= 1'b1;
               end
               else
                  wait_reg <= wait_reg - 4'h1;
            end
            default:
               state_reg <= ST_ACTIVE;
         endcase
      end
   end

   // clock gates {cpu, flash, io, adc, async, main, timer osc}
   reg [6:0] gate;

   always @*
   begin
      gate = {6'h3f, timer2_async};
      if (state_reg == ST_SLEEP)
      begin
         case (mode_reg)
            `CPSC_SM_IDLE:  gate = {2'h0, 4'hf, timer2_async};
            `CPSC_SM_QUIET: gate = {3'h0, 3'h7, timer2_async};
            `CPSC_SM_PDOWN: gate = 7'h00;
            `CPSC_SM_PSAVE: gate = {4'h0, 1'b1, 1'b0, timer2_async};
            `CPSC_SM_STBY:  gate = 7'h02;
            `CPSC_SM_ESTBY: gate = {4'h0, timer2_async, 1'b1, timer2_async};
            default:        gate = 7'h00;
         endcase
      end
      else if (state_reg != ST_ACTIVE)
         gate = {2'h0, 4'hf, timer2_async};
   end

   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cpu_clk_run   <= 1'b0;
         flash_clk_run <= 1'b0;
         io_clk_run    <= 1'b0;
         adc_clk_run   <= 1'b0;
         async_clk_run <= 1'b0;
         main_osc_run  <= 1'b0;
         timer_osc_run <= 1'b0;
         cpu_halt      <= 1'b1;
         sleeping      <= 1'b0;
      end
      else if (clk_en)
      begin
         cpu_clk_run   <= gate[6];
         flash_clk_run <= gate[5];
         io_clk_run    <= gate[4];
         adc_clk_run   <= gate[3];
         async_clk_run <= gate[2];
         main_osc_run  <= gate[1];
         timer_osc_run <= gate[0];
         cpu_halt      <= (state_reg != ST_ACTIVE) | ~init_done_reg;
         sleeping      <= (state_reg == ST_SLEEP);
      end
   end
endmodule // cpsc_top
`default_nettype wire

/* File: cpsc_top_chk.sv */
// port checker for the clock prescale and sleep control block
`timescale 1ns/1ps
`default_nettype none
module cpsc_chk (
   input wire logic core_clk,      // master clock
   input wire logic nrst,          // async reset, active low
   input wire logic psel,          // apb select
   input wire logic penable,       // apb enable
   input wire logic pready,        // apb ready
   input wire logic pslverr,       // apb error
   input wire logic sleep_instr,   // sleep pulse
   input wire logic timer2_async,  // timer2 clock mode
   input wire logic cpu_clk_run,   // cpu gate
   input wire logic flash_clk_run, // flash gate
   input wire logic io_clk_run,    // io gate
   input wire logic adc_clk_run,   // converter gate
   input wire logic async_clk_run, // async gate
   input wire logic main_osc_run,  // main source
   input wire logic timer_osc_run, // timer oscillator
   input wire logic cpu_halt,      // cpu held
   input wire logic cpu_resume,    // wake done pulse
   input wire logic sleeping       // sleep state
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);

   property p_apb_wait;
      psel && penable && !pready |=> pready;
   endproperty
   a_apb_wait: assert property (p_apb_wait) else $error("apb wait state missing");
   property p_err_rdy;
      pslverr |-> pready;
   endproperty
   a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
   property p_entry;
      $rose(sleeping) |-> $past(sleep_instr, 2);
   endproperty
   a_entry: assert property (p_entry) else $error("sleep without instruction");
   property p_cpu_off;
      sleeping |-> !cpu_clk_run && !flash_clk_run && cpu_halt;
   endproperty
   a_cpu_off: assert property (p_cpu_off) else $error("cpu clock runs in sleep");
   property p_tree;
      io_clk_run |-> adc_clk_run && async_clk_run && main_osc_run;
   endproperty
   a_tree: assert property (p_tree) else $error("io clock without its sources");
   property p_tosc;
      timer_osc_run && $stable(timer2_async) |-> timer2_async;
   endproperty
   a_tosc: assert property (p_tosc) else $error("timer osc on in sync mode");
   property p_halt4;
      cpu_resume |-> cpu_halt && $past(cpu_halt, 4);
   endproperty
   a_halt4: assert property (p_halt4) else $error("resume without halt");
   property p_pulse;
      cpu_resume |=> !cpu_resume;
   endproperty
   a_pulse: assert property (p_pulse) else $error("resume longer than a cycle");
   property p_wake;
      $fell(sleeping) |-> ##[1:16] cpu_resume;
   endproperty
   a_wake: assert property (p_wake) else $error("wake sequence too long");
endmodule // cpsc_chk

bind cpsc_top cpsc_chk i_chk (
   .core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable), .pready(pready),
   .pslverr(pslverr), .sleep_instr(sleep_instr), .timer2_async(timer2_async),
   .cpu_clk_run(cpu_clk_run), .flash_clk_run(flash_clk_run), .io_clk_run(io_clk_run),
   .adc_clk_run(adc_clk_run), .async_clk_run(async_clk_run), .main_osc_run(main_osc_run),
   .timer_osc_run(timer_osc_run), .cpu_halt(cpu_halt), .cpu_resume(cpu_resume), .sleeping(sleeping)
);
`default_nettype wire

/* File: tb.sv */
// self-checking bench for the clock prescale and sleep control block
`timescale 1ns/1ps
`default_nettype none
`include "cpsc_defs.vh"
module tb;
   localparam logic [11:0] A_PS = 12'(`CPSC_IDX_PRESCALE * 4);
   localparam logic [11:0] A_TR = 12'(`CPSC_IDX_TRIM * 4);
   localparam logic [11:0] A_SL = 12'(`CPSC_IDX_SLEEP * 4);
   localparam logic [11:0] A_ST = 12'(`CPSC_IDX_STATUS * 4);
   logic        core_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, er, fuse = 1'b0, sleep_instr = 1'b0, t2a = 1'b0;
   logic [7:0]  ftrim = 8'h00, tr, trim_value;
   logic [8:0]  src = 9'h000;
   logic [3:0]  lvl = 4'h0, dv;
   logic        t, lv, woke;
   wire  [6:0]  gt;
   wire         sys_clk_en, cpu_halt, cpu_resume, sleeping;
   logic [2:0]  ml [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
   logic [7:0]  rs [3] = '{8'h09, 8'h0b, 8'h0e};
   int          error_cnt = 0, cmp_count = 0, i, s, c, n, f;

   always #4 core_clk = ~core_clk;

   cpsc_top i_dut (
      .core_clk(core_clk), .nrst(nrst), .clk_en(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .divide_by_eight_fuse(fuse), .factory_trim(ftrim), .sleep_instr(sleep_instr),
      .ext_irq_lines({src[1], 6'h00, src[0]}), .ext_irq_upper_level(lvl), .pin_change_irq(src[2]),
      .twi_addr_match(src[3]), .watchdog_irq(src[4]), .timer2_irq(src[5]), .timer2_async(t2a),
      .mem_ready_irq(src[6]), .adc_irq(src[7]), .other_io_irq(src[8]), .sys_clk_en(sys_clk_en),
      .trim_value(trim_value), .cpu_clk_run(gt[6]), .flash_clk_run(gt[5]), .io_clk_run(gt[4]),
      .adc_clk_run(gt[3]), .async_clk_run(gt[2]), .main_osc_run(gt[1]), .timer_osc_run(gt[0]),
      .cpu_halt(cpu_halt), .cpu_resume(cpu_resume), .sleeping(sleeping)
   );

   // gates {cpu,flash,io,adc,async,main,tosc} in sleep
   function automatic logic [6:0] gexp(input logic [2:0] m, input logic a);
      case (m)
         3'h0: gexp = {6'b001111, a};
         3'h1: gexp = {6'b000111, a};
         3'h3: gexp = {5'b00001, 1'b0, a};
         3'h6: gexp = 7'b0000010;
         3'h7: gexp = {4'b0000, a, 1'b1, a};
         default: gexp = 7'b0000000;
      endcase
   endfunction

   // source 1 is an upper line, 5 timer2, 6 memory, 7 converter, 8 other io
   function automatic logic wexp(input logic [2:0] m, input int k, input logic l, input logic a);
      case (k)
         1: wexp = (m == 3'h0) || l;
         5: wexp = (m == 3'h0) || (m == 3'h3) || (m == 3'h7) || (m == 3'h1 && a);
         6, 7: wexp = (m <= 3'h1);
         8: wexp = (m == 3'h0);
         default: wexp = 1'b1;
      endcase
   endfunction

   task automatic chk(input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         error_cnt++;
         $display("wrong value at %0t: expected %h got %h", $time, e, g);
      end
   endtask

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic rst;
      nrst <= 1'b0;
      repeat (16) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (8) @(posedge core_clk);
   endtask

   // nx keeps the bus selected for a back-to-back transfer
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic nx);
      int k;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge core_clk) penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge core_clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20)
      begin
         error_cnt++;
         finish_test();
      end
      rd = prdata;
      er = pslverr;
      if (!nx)
      begin
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge core_clk);
      end
   endtask

   task automatic tick(output int k);
      k = 0;
      do
      begin
         @(posedge core_clk);
         k++;
      end while (sys_clk_en !== 1'b1 && k < 600);
      if (k >= 600)
      begin
         error_cnt++;
         finish_test();
      end
   endtask

   task automatic wres(output logic w);
      w = 1'b0;
      for (int k = 0; k < 40 && !w; k++)
      begin
         @(posedge core_clk);
         w = (cpu_resume === 1'b1);
      end
   endtask

   task automatic slp(input logic [7:0] v);
      apb(1'b1, A_SL, v, 1'b0);
      sleep_instr <= 1'b1;
      @(posedge core_clk) sleep_instr <= 1'b0;
      repeat (3) @(posedge core_clk);
   endtask

   initial
   begin
      void'($urandom(61));
      for (f = 0; f < 2; f++)
      begin
         tr = 8'($urandom);
         fuse <= f[0];
         ftrim <= tr;
         rst();
         apb(1'b0, A_PS, 8'h00, 1'b0);
         chk(f ? 32'h3 : 32'h0, rd);
         apb(1'b0, A_TR, 8'h00, 1'b0);
         chk(32'(tr), rd);
      end
      $display("reset test done");
      for (c = 0; c < 6; c++)
      begin
         tr = (c < 2) ? 8'h7f + 8'(c) : 8'($urandom);
         apb(1'b1, A_TR, tr, 1'b0);
         apb(1'b0, A_TR, 8'h00, 1'b0);
         chk(32'(tr), rd);
         chk(32'(tr), 32'(trim_value));
      end
      $display("trim test done");
      dv = 4'h3;
      apb(1'b1, A_PS, 8'h80, 1'b1);
      apb(1'b0, A_PS, 8'h00, 1'b0);
      chk(32'h80 | 32'(dv), rd);
      repeat (40) @(posedge core_clk);
      apb(1'b0, A_ST, 8'h00, 1'b0);
      chk(32'h80 | 32'(dv), rd);
      for (c = 0; c < 16; c++)
      begin
         apb(1'b1, A_PS, 8'h80, 1'b1);
         apb(1'b1, A_PS, 8'(c), 1'b0);
         if (c <= 8)
            dv = 4'(c);
         apb(1'b0, A_PS, 8'h00, 1'b0);
         chk(32'(dv), rd);
         tick(n);
         tick(n);
         tick(n);
         chk(32'(1) << dv, 32'(n));
      end
      apb(1'b1, A_PS, 8'h81, 1'b0);
      apb(1'b1, A_PS, 8'h02, 1'b0);
      apb(1'b0, A_PS, 8'h00, 1'b0);
      chk(32'h8, rd);
      apb(1'b1, A_PS, 8'h80, 1'b1);
      apb(1'b1, A_PS, 8'h01, 1'b0);
      // factor 2 must be active so the window below has a known length
      tick(n);
      apb(1'b1, A_PS, 8'h80, 1'b1);
      apb(1'b1, A_PS, 8'h80, 1'b1);
      apb(1'b1, A_PS, 8'h02, 1'b0);
      apb(1'b0, A_PS, 8'h00, 1'b0);
      chk(32'h2, rd);
      apb(1'b1, A_PS, 8'h80, 1'b0);
      repeat (7) @(posedge core_clk);
      apb(1'b1, A_PS, 8'h80, 1'b0);
      repeat (5) @(posedge core_clk);
      apb(1'b1, A_PS, 8'h03, 1'b0);
      apb(1'b0, A_ST, 8'h00, 1'b0);
      chk(32'h82, rd);
      apb(1'b1, A_PS, 8'h80, 1'b1);
      apb(1'b1, A_PS, 8'h00, 1'b0);
      apb(1'b0, 12'h000, 8'h00, 1'b0);
      chk(32'h1, 32'(er));
      chk(32'h0, rd);
      $display("prescale test done");
      for (i = 0; i < 6; i++)
      begin
         for (s = 0; s < 9; s++)
         begin
            t = 1'($urandom);
            lv = 1'($urandom);
            t2a <= t;
            lvl <= {4{lv}};
            slp({4'h0, ml[i], 1'b1});
            chk(32'h1, 32'(sleeping));
            chk(32'(gexp(ml[i], t)), 32'(gt));
            src[s] <= 1'b1;
            wres(woke);
            src <= 9'h000;
            chk(32'(wexp(ml[i], s, lv, t)), 32'(woke));
            if (!woke)
            begin
               @(posedge core_clk) src[4] <= 1'b1;
               wres(woke);
               src <= 9'h000;
               chk(32'h1, 32'(woke));
            end
         end
      end
      for (c = 0; c < 3; c++)
      begin
         slp(rs[c]);
         chk(32'h0, 32'(sleeping));
      end
      $display("sleep test done");
      slp(8'h05);
      chk(32'h1, 32'(sleeping));
      rst();
      chk(32'h0, 32'(sleeping));
      chk(32'h0, 32'(cpu_halt));
      $display("reset in sleep test done");
      finish_test();
   end
endmodule // tb
`default_nettype wire
